// [jtras_consts.vh]
`ifndef JTRAS_CONSTS_VH
`define JTRAS_CONSTS_VH

// tap controller state codes
`define JTRAS_ST_RESET      4'h0
`define JTRAS_ST_IDLE       4'h1
`define JTRAS_ST_SEL_DR     4'h2
`define JTRAS_ST_CAP_DR     4'h3
`define JTRAS_ST_SHIFT_DR   4'h4
`define JTRAS_ST_EXIT1_DR   4'h5
`define JTRAS_ST_PAUSE_DR   4'h6
`define JTRAS_ST_EXIT2_DR   4'h7
`define JTRAS_ST_UPD_DR     4'h8
`define JTRAS_ST_SEL_IR     4'h9
`define JTRAS_ST_CAP_IR     4'hA
`define JTRAS_ST_SHIFT_IR   4'hB
`define JTRAS_ST_EXIT1_IR   4'hC
`define JTRAS_ST_PAUSE_IR   4'hD
`define JTRAS_ST_EXIT2_IR   4'hE
`define JTRAS_ST_UPD_IR     4'hF

// instruction codes
`define JTRAS_INS_EXTEST    3'h0
`define JTRAS_INS_ANALOG    3'h2
`define JTRAS_INS_SAMPLE    3'h4
`define JTRAS_INS_IDCODE    3'h6
`define JTRAS_INS_BYPASS    3'h7
`define JTRAS_IR_CAPTURE    3'h1

// data register selectors
`define JTRAS_DR_BSC        2'h0
`define JTRAS_DR_ASR        2'h1
`define JTRAS_DR_ID         2'h2
`define JTRAS_DR_BYP        2'h3

// widths
`define JTRAS_IR_W          3
`define JTRAS_ASR_W         5
`define JTRAS_ID_W          32
`define JTRAS_BSC_W         99

// analog code groups: top two bits pick tx or rx, low three are 7-n
`define JTRAS_ASR_TX_GRP    2'h3
`define JTRAS_ASR_RX_GRP    2'h2
`define JTRAS_ASR_RESET     5'h00

// identification fields
`define JTRAS_ID_REV_LSB    28
`define JTRAS_ID_PART_LSB   12
`define JTRAS_ID_MFR_LSB    1

// receive-output tristate cell positions in the boundary chain
`define JTRAS_HIZ_POS0      7
`define JTRAS_HIZ_POS1      15
`define JTRAS_HIZ_POS2      23
`define JTRAS_HIZ_POS3      31
`define JTRAS_HIZ_POS4      71
`define JTRAS_HIZ_POS5      63
`define JTRAS_HIZ_POS6      86
`define JTRAS_HIZ_POS7      78

`endif

// [jtras_tap_ctl.sv]
`timescale 1ns/1ps
module jtras_tap_ctl (
  // clock
  input  wire clk,
  // test port pins
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo
);
  // shift pauses once after this bit, through the pause states
  int pause_at = -1;
  // tck stands low between steps; 8 clk per tck period
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tdo read late in the high phase, well after it settled
  task step(input logic m, input logic d, output logic q);
    begin
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      q = tdo;
      tck <= 1'b0;
    end
  endtask
  task tlr;
    logic q;
    begin
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
    end
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task shift(input logic ir, input logic [98:0] d, input int n,
             output logic [98:0] q);
    logic b;
    begin
      q = '0;
      step(1'b1, 1'b0, b);
      if (ir) step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
        step(i == n - 1 || i == pause_at, d[i], b);
        q[i] = b;
        if (i == pause_at && i < n - 1) begin
          step(1'b0, 1'b0, b);
          step(1'b0, 1'b0, b);
          step(1'b1, 1'b0, b);
          step(1'b0, 1'b0, b);
        end
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
    end
  endtask
endmodule // jtras_tap_ctl

// [jtras_test_port.v]
`timescale 1ns/1ps
`include "jtras_consts.vh"

// Behaviour
// - five-bit analog register on chain under analog instruction
// - five rising test clocks load full analog code
// - analog code enters least significant bit first
// - decode sixteen codes to tx/rx pair selects
// - 32-bit id: revision, part, maker, one
// - id register shifts out lsb first
// - one-bit bypass between data in and out
// - three-bit instruction register, lsb first
// - extest: chain on, capture pins, drive outputs
// - code 010 selects analog register, enables pins
// - sample/preload: chain on, normal path kept
// - idcode routes identification register to output
// - bypass code passes data through one bit
// - data output changes only after falling test clock
// - rx tristate cell: 0 enables, 1 tristates
module jtras_test_port #(
  parameter [3:0]  ID_REVISION = 4'h1,    // arbitrary value
  parameter [15:0] ID_PART     = 16'h1234, // arbitrary value
  parameter [10:0] ID_MAKER    = 11'h055  // arbitrary value
) (
  // clock and reset
  input  wire                    clk,
  input  wire                    nrst,
  // test access port pins
  input  wire                    tck,
  input  wire                    tms,
  input  wire                    tdi,
  output reg                     tdo_r,
  output reg                     tdo_oe_r,
  // boundary cell chain, pin side
  input  wire [`JTRAS_BSC_W-1:0] bsc_pin_in,
  output reg  [`JTRAS_BSC_W-1:0] bsc_drive_r,
  output reg                     bsc_extest_r,
  output reg  [7:0]              rx_out_en_r,
  // analog test port pair selects and current instruction
  output reg  [7:0]              tx_pair_sel_r,
  output reg  [7:0]              rx_pair_sel_r,
  output reg  [2:0]              instr_r
);

  // data register picked by an instruction; unlisted codes fall to bypass
  function [1:0] dr_pick;
    input [2:0] ins;
    begin
      case (ins)
        `JTRAS_INS_EXTEST: dr_pick = `JTRAS_DR_BSC;
        `JTRAS_INS_SAMPLE: dr_pick = `JTRAS_DR_BSC;
        `JTRAS_INS_ANALOG: dr_pick = `JTRAS_DR_ASR;
        `JTRAS_INS_IDCODE: dr_pick = `JTRAS_DR_ID;
        default:           dr_pick = `JTRAS_DR_BYP;
      endcase
    end
  endfunction

  // one-hot pair for an analog code, empty when its group bits differ
  function [7:0] pair_pick;
    input [4:0] code;
    input [1:0] grp;
    begin
      pair_pick = 8'h00;
      if (code[4:3] == grp)
        pair_pick[3'h7 - code[2:0]] = 1'b1;
    end
  endfunction

  // synchronisers: pins come from the tester's clock domain
  reg        tck_s1_r;
  reg        tck_s2_r;
  reg        tck_s3_r;
  reg        tms_s1_r;
  reg        tms_s2_r;
  reg        tdi_s1_r;
  reg        tdi_s2_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_s3_r <= 1'b0;
      tms_s1_r <= 1'b1;
      tms_s2_r <= 1'b1;
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
    end else begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
      tms_s1_r <= tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= tdi;
      tdi_s2_r <= tdi_s1_r;
    end
  end

  // third stage only finds edges; each tck phase needs three clocks
  wire tck_rise = tck_s2_r & ~tck_s3_r;
  wire tck_fall = ~tck_s2_r & tck_s3_r;

  // chain inputs cross in through two stages like the port pins
  // each cell is its own pin, so no word coherence is needed
  reg  [`JTRAS_BSC_W-1:0] pin_s1_r;
  reg  [`JTRAS_BSC_W-1:0] pin_s2_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r <= {`JTRAS_BSC_W{1'b0}};
      pin_s2_r <= {`JTRAS_BSC_W{1'b0}};
    end else begin
      pin_s1_r <= bsc_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // tap controller
  reg  [3:0] state_r;
  reg  [3:0] state_nxt;

  always @* begin
    case (state_r)
      `JTRAS_ST_RESET:
        state_nxt = tms_s2_r ? `JTRAS_ST_RESET : `JTRAS_ST_IDLE;
      `JTRAS_ST_IDLE:
        state_nxt = tms_s2_r ? `JTRAS_ST_SEL_DR : `JTRAS_ST_IDLE;
      `JTRAS_ST_SEL_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_SEL_IR : `JTRAS_ST_CAP_DR;
      `JTRAS_ST_CAP_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_EXIT1_DR : `JTRAS_ST_SHIFT_DR;
      `JTRAS_ST_SHIFT_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_EXIT1_DR : `JTRAS_ST_SHIFT_DR;
      `JTRAS_ST_EXIT1_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_UPD_DR : `JTRAS_ST_PAUSE_DR;
      `JTRAS_ST_PAUSE_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_EXIT2_DR : `JTRAS_ST_PAUSE_DR;
      `JTRAS_ST_EXIT2_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_UPD_DR : `JTRAS_ST_SHIFT_DR;
      `JTRAS_ST_UPD_DR:
        state_nxt = tms_s2_r ? `JTRAS_ST_SEL_DR : `JTRAS_ST_IDLE;
      `JTRAS_ST_SEL_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_RESET : `JTRAS_ST_CAP_IR;
      `JTRAS_ST_CAP_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_EXIT1_IR : `JTRAS_ST_SHIFT_IR;
      `JTRAS_ST_SHIFT_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_EXIT1_IR : `JTRAS_ST_SHIFT_IR;
      `JTRAS_ST_EXIT1_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_UPD_IR : `JTRAS_ST_PAUSE_IR;
      `JTRAS_ST_PAUSE_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_EXIT2_IR : `JTRAS_ST_PAUSE_IR;
      `JTRAS_ST_EXIT2_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_UPD_IR : `JTRAS_ST_SHIFT_IR;
      `JTRAS_ST_UPD_IR:
        state_nxt = tms_s2_r ? `JTRAS_ST_SEL_DR : `JTRAS_ST_IDLE;
      default:
        state_nxt = `JTRAS_ST_RESET;
    endcase
  end

  // state moves only on a seen rising edge of the test clock
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      state_r <= `JTRAS_ST_RESET;
    else if (tck_rise)
      state_r <= state_nxt;
  end

  // shift stages and held registers
  reg  [`JTRAS_IR_W-1:0]  ir_sr_r;
  reg  [`JTRAS_ASR_W-1:0] asr_sr_r;
  reg  [`JTRAS_ASR_W-1:0] asr_r;
  reg  [`JTRAS_ID_W-1:0]  id_sr_r;
  reg  [`JTRAS_BSC_W-1:0] bsc_sr_r;
  reg                     byp_r;

  wire [1:0] dr_sel = dr_pick(instr_r);
  wire [`JTRAS_ID_W-1:0] id_value = {ID_REVISION, ID_PART, ID_MAKER,
                                     1'b1};

  wire in_shift_dr = (state_r == `JTRAS_ST_SHIFT_DR);
  wire in_shift_ir = (state_r == `JTRAS_ST_SHIFT_IR);
  wire in_cap_dr   = (state_r == `JTRAS_ST_CAP_DR);
  wire in_cap_ir   = (state_r == `JTRAS_ST_CAP_IR);
  wire in_upd_ir   = (state_r == `JTRAS_ST_UPD_IR);
  wire in_upd_dr   = (state_r == `JTRAS_ST_UPD_DR);
  wire in_tlr      = (state_r == `JTRAS_ST_RESET);

  // instruction stage: capture pattern, then shift, new bits at the top
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ir_sr_r <= `JTRAS_IR_CAPTURE;
    else if (tck_rise) begin
      if (in_cap_ir)
        ir_sr_r <= `JTRAS_IR_CAPTURE;
      else if (in_shift_ir)
        ir_sr_r <= {tdi_s2_r, ir_sr_r[`JTRAS_IR_W-1:1]};
    end
  end

  // bypass stage: zero on capture, one bit of delay while shifting
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      byp_r <= 1'b0;
    else if (tck_rise && dr_sel == `JTRAS_DR_BYP) begin
      if (in_cap_dr)
        byp_r <= 1'b0;
      else if (in_shift_dr)
        byp_r <= tdi_s2_r;
    end
  end

  // data stages capture and shift on a rising test clock
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asr_sr_r <= `JTRAS_ASR_RESET;
      id_sr_r  <= {`JTRAS_ID_W{1'b0}};
      bsc_sr_r <= {`JTRAS_BSC_W{1'b0}};
    end else if (tck_rise) begin
      if (in_cap_dr) begin
        case (dr_sel)
          `JTRAS_DR_BSC: bsc_sr_r <= pin_s2_r;
          `JTRAS_DR_ASR: asr_sr_r <= asr_r;
          `JTRAS_DR_ID:  id_sr_r  <= id_value;
          default: ;
        endcase
      end else if (in_shift_dr) begin
        case (dr_sel)
          `JTRAS_DR_BSC:
            bsc_sr_r <= {tdi_s2_r, bsc_sr_r[`JTRAS_BSC_W-1:1]};
          `JTRAS_DR_ASR:
            asr_sr_r <= {tdi_s2_r, asr_sr_r[`JTRAS_ASR_W-1:1]};
          `JTRAS_DR_ID:
            id_sr_r  <= {tdi_s2_r, id_sr_r[`JTRAS_ID_W-1:1]};
          default: ;
        endcase
      end
    end
  end

  // update on falling test clock, so held values never change mid-shift
  // reset state wins every clock, so a late update cannot retie a pair
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instr_r     <= `JTRAS_INS_IDCODE;
      asr_r       <= `JTRAS_ASR_RESET;
      bsc_drive_r <= {`JTRAS_BSC_W{1'b0}};
    end else if (in_tlr) begin
      instr_r <= `JTRAS_INS_IDCODE;
      asr_r   <= `JTRAS_ASR_RESET;
    end else if (tck_fall) begin
      if (in_upd_ir)
        instr_r <= ir_sr_r;
      if (in_upd_dr) begin
        if (dr_sel == `JTRAS_DR_ASR)
          asr_r <= asr_sr_r;
        if (dr_sel == `JTRAS_DR_BSC)
          bsc_drive_r <= bsc_sr_r;
      end
    end
  end

  // serial output: moves only on a falling test clock
  reg tdo_nxt;

  always @* begin
    if (in_shift_ir) begin
      tdo_nxt = ir_sr_r[0];
    end else begin
      case (dr_sel)
        `JTRAS_DR_BSC: tdo_nxt = bsc_sr_r[0];
        `JTRAS_DR_ASR: tdo_nxt = asr_sr_r[0];
        `JTRAS_DR_ID:  tdo_nxt = id_sr_r[0];
        default:       tdo_nxt = byp_r;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tdo_r <= 1'b0;
    else if (tck_fall)
      tdo_r <= tdo_nxt;
  end

  // enable follows the shift states and moves on the same fall
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tdo_oe_r <= 1'b0;
    else if (tck_fall)
      tdo_oe_r <= in_shift_ir | in_shift_dr;
  end

  // analog pair decode; nothing is tied outside the analog instruction
  reg [7:0] tx_sel_nxt;
  reg [7:0] rx_sel_nxt;

  always @* begin
    tx_sel_nxt = 8'h00;
    rx_sel_nxt = 8'h00;
    if (instr_r == `JTRAS_INS_ANALOG) begin
      tx_sel_nxt = pair_pick(asr_r, `JTRAS_ASR_TX_GRP);
      rx_sel_nxt = pair_pick(asr_r, `JTRAS_ASR_RX_GRP);
    end
  end

  // receive output enables; boundary cells rule only under extest
  wire [7:0] hiz_cells = {bsc_drive_r[`JTRAS_HIZ_POS7],
                          bsc_drive_r[`JTRAS_HIZ_POS6],
                          bsc_drive_r[`JTRAS_HIZ_POS5],
                          bsc_drive_r[`JTRAS_HIZ_POS4],
                          bsc_drive_r[`JTRAS_HIZ_POS3],
                          bsc_drive_r[`JTRAS_HIZ_POS2],
                          bsc_drive_r[`JTRAS_HIZ_POS1],
                          bsc_drive_r[`JTRAS_HIZ_POS0]};
  wire       extest_now = (instr_r == `JTRAS_INS_EXTEST);

  // analog pins released whenever the held code leaves both groups
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_pair_sel_r <= 8'h00;
      rx_pair_sel_r <= 8'h00;
    end else begin
      tx_pair_sel_r <= tx_sel_nxt;
      rx_pair_sel_r <= rx_sel_nxt;
    end
  end

  // rx outputs stay enabled unless extest hands them to the cells
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bsc_extest_r <= 1'b0;
      rx_out_en_r  <= 8'hFF;
    end else begin
      bsc_extest_r <= extest_now;
      rx_out_en_r  <= extest_now ? ~hiz_cells : 8'hFF;
    end
  end

endmodule // jtras_test_port

// [jtras_test_port_asserts.sv]
`timescale 1ns/1ps
`include "jtras_consts.vh"
module jtras_test_port_chk (
  // clock and reset
  input logic                    clk,
  input logic                    nrst,
  // test port
  input logic                    tck,
  input logic                    tdo_r,
  input logic                    tdo_oe_r,
  // pin side and current instruction
  input logic [`JTRAS_BSC_W-1:0] bsc_drive_r,
  input logic                    bsc_extest_r,
  input logic [7:0]              rx_out_en_r,
  input logic [7:0]              tx_pair_sel_r,
  input logic [7:0]              rx_pair_sel_r,
  input logic [2:0]              instr_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // one-clock lag allowed between instruction and pin controls
  sequence s_ext_steady;
    (instr_r == `JTRAS_INS_EXTEST && $stable(bsc_drive_r)) [*2];
  endsequence
  sequence s_not_ext;
    (instr_r != `JTRAS_INS_EXTEST) [*2];
  endsequence
  a_tdo_after_fall: assert property ($changed(tdo_r) |->
    !$past(tck, 2) && $past(tck, 5)) else $error("tdo moved off a fall");
  a_oe_after_fall: assert property ($changed(tdo_oe_r) |->
    !$past(tck, 2) && $past(tck, 5)) else $error("tdo enable off a fall");
  a_extest_flag_on: assert property (s_ext_steady |-> bsc_extest_r)
    else $error("extest flag low");
  a_extest_flag_off: assert property (s_not_ext |-> !bsc_extest_r)
    else $error("extest flag high");
  a_rx_en_normal: assert property (s_not_ext |-> rx_out_en_r == 8'hFF)
    else $error("rx outputs disabled outside extest");
  a_rx_en_hiz: assert property (s_ext_steady |-> rx_out_en_r ==
    ~{bsc_drive_r[`JTRAS_HIZ_POS7], bsc_drive_r[`JTRAS_HIZ_POS6],
      bsc_drive_r[`JTRAS_HIZ_POS5], bsc_drive_r[`JTRAS_HIZ_POS4],
      bsc_drive_r[`JTRAS_HIZ_POS3], bsc_drive_r[`JTRAS_HIZ_POS2],
      bsc_drive_r[`JTRAS_HIZ_POS1], bsc_drive_r[`JTRAS_HIZ_POS0]})
    else $error("rx enable not from tristate cells");
  a_pair_onehot: assert property (
    $onehot0({tx_pair_sel_r, rx_pair_sel_r}))
    else $error("more than one pair on analog pins");
  a_pair_needs_analog: assert property (
    |{tx_pair_sel_r, rx_pair_sel_r} |->
    instr_r == `JTRAS_INS_ANALOG || $past(instr_r) == `JTRAS_INS_ANALOG)
    else $error("pair tied without analog instruction");
endmodule // jtras_test_port_chk
bind jtras_test_port jtras_test_port_chk u_chk (.clk(clk), .nrst(nrst),
  .tck(tck), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r), .bsc_drive_r(bsc_drive_r),
  .bsc_extest_r(bsc_extest_r), .rx_out_en_r(rx_out_en_r),
  .tx_pair_sel_r(tx_pair_sel_r), .rx_pair_sel_r(rx_pair_sel_r),
  .instr_r(instr_r));

// [test_jtras_test_port.sv]
`timescale 1ns/1ps
`include "jtras_consts.vh"
module test_jtras_test_port;
  localparam [31:0] ID = {4'hA, 16'h5C3E, 11'h2B7, 1'b1}; // arbitrary
  logic clk = 1'b0, nrst = 1'b0;
  logic [98:0] pin_in = '0, q, d;
  logic [7:0] ex;
  logic [4:0] code, prev;
  wire tck, tms, tdi, tdo, oe, ext;
  wire [98:0] drv;
  wire [7:0] rxen, txs, rxs;
  wire [2:0] ins;
  int n_mismatch = 0, n_compared = 0;
  int n_oe = 0, oe_base;
  int pos [8] = '{`JTRAS_HIZ_POS0, `JTRAS_HIZ_POS1, `JTRAS_HIZ_POS2,
    `JTRAS_HIZ_POS3, `JTRAS_HIZ_POS4, `JTRAS_HIZ_POS5, `JTRAS_HIZ_POS6,
    `JTRAS_HIZ_POS7};
  always #12.5 clk = ~clk;
  always @(posedge clk) if (oe === 1'b1) n_oe <= n_oe + 1;
  // released tdo shows the inverse, so a read outside a shift is caught
  jtras_tap_ctl u_ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(oe ? tdo : ~tdo));
  jtras_test_port #(.ID_REVISION(4'hA), .ID_PART(16'h5C3E),
    .ID_MAKER(11'h2B7)) DUT (.clk(clk), .nrst(nrst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo_r(tdo), .tdo_oe_r(oe), .bsc_pin_in(pin_in),
    .bsc_drive_r(drv), .bsc_extest_r(ext), .rx_out_en_r(rxen),
    .tx_pair_sel_r(txs), .rx_pair_sel_r(rxs), .instr_r(ins));
  task chk(input string nm, input logic [98:0] e, input logic [98:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("instr", `JTRAS_INS_IDCODE, ins);
    chk("rx_en", 8'hFF, rxen);
    u_ctl.tlr();
    oe_base = n_oe;
    u_ctl.shift(1'b0, '0, 32, q);
    chk("idcode", ID, q);
    chk("oe_cycles", 32 * 8, n_oe - oe_base);
    $display("test idcode done");
    foreach (pos[i]) if (i < 4) begin
      u_ctl.shift(1'b1, 3'h7 - 2 * i, 3, q);
      chk("ir_cap", `JTRAS_IR_CAPTURE, q);
      u_ctl.shift(1'b0, 8'h5A, 9, q);
      chk("bypass", 9'h0B4, q);
    end
    $display("test bypass done");
    u_ctl.pause_at = 1;
    u_ctl.shift(1'b1, `JTRAS_INS_ANALOG, 3, q);
    chk("instr", `JTRAS_INS_ANALOG, ins);
    prev = `JTRAS_ASR_RESET;
    for (int k = 0; k < 16; k++) begin
      code = (k < 8 ? 5'h1F : 5'h1F - 5'h08) - 5'(k % 8);
      u_ctl.shift(1'b0, code, 5, q);
      chk("asr_out", prev, q);
      chk("tx_sel", k < 8 ? 8'h01 << k : 8'h00, txs);
      chk("rx_sel", k < 8 ? 8'h00 : 8'h01 << (k - 8), rxs);
      prev = code;
    end
    u_ctl.shift(1'b0, 5'h0F, 5, q);
    chk("asr_out", prev, q);
    chk("pairs", 16'h0000, {txs, rxs});
    u_ctl.tlr();
    chk("instr", `JTRAS_INS_IDCODE, ins);
    chk("pairs", 16'h0000, {txs, rxs});
    $display("test analog done");
    foreach (pos[i]) if (i < 2) begin
      d = {3'h2, {12{8'hA6}}} ^ i;
      pin_in <= {3'h5, {12{8'h3C}}} ^ (i + 1);
      u_ctl.shift(1'b1, 3'h4 * i, 3, q);
      chk("extest", i == 0, ext);
      u_ctl.shift(1'b0, d, 99, q);
      chk("capture", pin_in, q);
      for (int c = 0; c < 8; c++) ex[c] = i == 0 ? ~d[pos[c]] : 1'b1;
      chk("rx_en", ex, rxen);
      if (i == 0) chk("drive", d, drv);
    end
    $display("test boundary done");
    tally_and_finish();
  end
endmodule // test_jtras_test_port
